// ---- hw/vectored_interrupt_controller.sv ----
// Our own choices: the AXI4-Lite slave port and the register addresses.
module vectored_interrupt_controller
   import vic_pkg::*;
(
   input wire logic i_ref_clk,                   // System clock
   input wire logic i_reset,                     // Async reset, high
   input wire logic [NUM_SRC-1:0] i_src_request, // Peripheral request pulses/levels
   input wire logic i_ext_zero,                  // External request zero pin
   input wire logic i_ext_one,                   // External request one pin
   input wire logic i_ext_two,                   // External request two pin
   input wire logic [3:0] i_cpu_level,           // Current CPU priority level
   input wire logic [5:0] i_trap_event,          // Trap status set pulses
   input wire logic i_ack,                       // CPU took the pending request
   output logic o_irq,                           // Request to CPU
   output logic [6:0] o_vector,                  // Latched vector number
   output logic [3:0] o_new_level,               // Latched new level
   output logic [23:0] o_vector_addr,            // Table entry address
   output logic o_nesting_disable,               // Nesting control level
   output logic [23:0] o_reset_pc,               // Program counter after reset
   input wire logic [31:0] i_awaddr,             // AXI write address
   input wire logic i_awvalid,                   // AXI write address valid
   output logic o_awready,                       // AXI write address ready
   input wire logic [31:0] i_wdata,              // AXI write data
   input wire logic [3:0] i_wstrb,               // AXI write strobes
   input wire logic i_wvalid,                    // AXI write data valid
   output logic o_wready,                        // AXI write data ready
   output logic [1:0] o_bresp,                   // AXI write response
   output logic o_bvalid,                        // AXI write response valid
   input wire logic i_bready,                    // AXI write response ready
   input wire logic [31:0] i_araddr,             // AXI read address
   input wire logic i_arvalid,                   // AXI read address valid
   output logic o_arready,                       // AXI read address ready
   output logic [31:0] o_rdata,                  // AXI read data
   output logic [1:0] o_rresp,                   // AXI read response
   output logic o_rvalid,                        // AXI read valid
   input wire logic i_rready                     // AXI read ready
);
   import vic_pkg::*;

   // ****
   // Storage
   // ****
   logic [15:0] global_irq_control_first;              // Nesting, trap flags
   logic [15:0] global_irq_control_second;             // Table select, edges
   logic [NUM_SRC-1:0] request_flag_regs;              // Sticky flags
   logic [NUM_SRC-1:0] request_enable_regs;            // Enables
   logic [2:0] source_priority_regs [NUM_SRC];         // Priority fields
   logic [6:0] pending_vector_number;                  // Latched vector
   logic [3:0] pending_new_level;                      // Latched level
   logic [NUM_SRC-1:0] set_event;                      // Combined set pulses
   logic [2:0] ext_edge;                               // External edges
   logic aw_held, w_held;                              // Write halves taken
   logic [31:0] aw_addr, w_data;                       // Held write halves
   logic [3:0] w_strb;                                 // Held strobes
   logic do_write;                                     // Write commits now
   logic [NUM_SRC-1:0] wr_flag_mask, wr_flag_val;      // Flag write effect
   logic [6:0] next_vector;                            // Arbitration winner
   logic [3:0] next_level;                             // Winner priority
   logic next_valid;                                   // Any eligible source
   logic [31:0] rd_word;                               // Read mux
   logic rd_ok;                                        // Read address mapped
   logic wr_ok;                                        // Write address mapped

   // ****
   // External request edge detectors
   // ****
   vic_edge_detect u_edge_zero
   (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_level(i_ext_zero),
      .i_negative(global_irq_control_second[0]), // RULE_12
      .o_edge(ext_edge[0])
   );
   vic_edge_detect u_edge_one
   (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_level(i_ext_one),
      .i_negative(global_irq_control_second[1]),
      .o_edge(ext_edge[1])
   );
   vic_edge_detect u_edge_two
   (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_level(i_ext_two),
      .i_negative(global_irq_control_second[2]),
      .o_edge(ext_edge[2])
   );

   // Pins into slots 8, 28, 37; reserved dropped
   always_comb
   begin
      set_event = i_src_request & SRC_IMPL[NUM_SRC-1:0]; // RULE_23
      set_event[0] = ext_edge[0];  // RULE_04
      set_event[20] = ext_edge[1]; // RULE_09
      set_event[29] = ext_edge[2]; // RULE_09
   end

   // ****
   // AXI write channel
   // ****
   assign o_awready = ~aw_held & ~o_bvalid;
   assign o_wready = ~w_held & ~o_bvalid;
   assign do_write = aw_held & w_held & ~o_bvalid;

   // Address and data in either order
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 32'h0000_0000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
         end
         if (i_wvalid && o_wready)
         begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (o_bvalid && i_bready)
         begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // Decode of write address
   always_comb
   begin
      wr_ok = (aw_addr[31:8] == 24'h000000) && (aw_addr[1:0] == 2'h0)
         && (aw_addr[7:0] <= OFF_PENDING);
      wr_flag_mask = '0;
      wr_flag_val = '0;
      for (int i = 0; i < NUM_FLAG_REGS; i++)
      begin
         if (do_write && aw_addr[7:0] == OFF_FLAG_BASE + 8'(4 * i))
         begin
            for (int b = 0; b < 16; b++)
            begin
               if (16 * i + b < NUM_SRC && w_strb[b / 8])
               begin
                  wr_flag_mask[16 * i + b] = 1'b1;
                  wr_flag_val[16 * i + b] = w_data[b];
               end
            end
         end
      end
   end

   // ****
   // Control registers
   // ****
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         global_irq_control_first <= 16'h0000;  // RULE_01
         global_irq_control_second <= 16'h0000; // RULE_01
      end
      else
      begin
         if (do_write && aw_addr[7:0] == OFF_CTRL_FIRST && w_strb[1:0] == 2'h3)
         begin
            global_irq_control_first <= w_data[15:0] & CTRL_FIRST_MASK; // RULE_11
         end
         else
         begin
            // Trap status sets, hardware wins
            global_irq_control_first[6:1] <= global_irq_control_first[6:1] | i_trap_event;
         end
         if (do_write && aw_addr[7:0] == OFF_CTRL_SECOND && w_strb[1:0] == 2'h3)
         begin
            global_irq_control_second <= w_data[15:0] & CTRL_SECOND_MASK; // RULE_12
         end
         if (do_write && aw_addr[7:0] == OFF_CTRL_FIRST && w_strb[1:0] == 2'h3)
         begin
            global_irq_control_first[6:1] <= (w_data[6:1]) | i_trap_event;
         end
      end
   end

   // ****
   // Flags: set by hardware, cleared by write
   // ****
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         request_flag_regs <= '0;
      end
      else
      begin
         // Set wins over a same-cycle clear
         request_flag_regs <= (((request_flag_regs & ~wr_flag_mask) | (wr_flag_val & wr_flag_mask))
            | set_event) & SRC_IMPL[NUM_SRC-1:0]; // RULE_13
      end
   end

   // ****
   // Enables and priorities
   // ****
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         request_enable_regs <= '0;
         for (int s = 0; s < NUM_SRC; s++)
         begin
            source_priority_regs[s] <= 3'h0;
         end
      end
      else if (do_write)
      begin
         for (int i = 0; i < NUM_FLAG_REGS; i++)
         begin
            for (int b = 0; b < 16; b++)
            begin
               if (16 * i + b < NUM_SRC && w_strb[b / 8]
                  && aw_addr[7:0] == OFF_ENABLE_BASE + 8'(4 * i))
               begin
                  request_enable_regs[16 * i + b] <= w_data[b]
                     & SRC_IMPL[16 * i + b]; // RULE_14
               end
            end
         end
         for (int i = 0; i < NUM_PRIO_REGS; i++)
         begin
            for (int f = 0; f < 4; f++)
            begin
               if (4 * i + f < NUM_SRC && w_strb[f / 2]
                  && aw_addr[7:0] == OFF_PRIO_BASE + 8'(4 * i))
               begin
                  // Field f at bits 4f+2:4f
                  source_priority_regs[4 * i + f] <= SRC_IMPL[4 * i + f]
                     ? w_data[4 * f +: 3] : 3'h0; // RULE_15 RULE_18
               end
            end
         end
      end
   end

   // ****
   // Arbitration
   // ****
   always_comb
   begin
      next_valid = 1'b0;
      next_vector = 7'h00;
      next_level = 4'h0;
      // Strict greater keeps lowest vector on ties
      for (int s = 0; s < NUM_SRC; s++)
      begin
         if (request_flag_regs[s] && request_enable_regs[s] && SRC_IMPL[s]
            && {1'b0, source_priority_regs[s]} > i_cpu_level
            && (!next_valid || {1'b0, source_priority_regs[s]} > next_level)) // RULE_20 RULE_22
         begin
            next_valid = 1'b1;
            next_vector = 7'(s + NUM_TRAPS); // RULE_06 RULE_07 RULE_08 RULE_19
            next_level = {1'b0, source_priority_regs[s]}; // RULE_17
         end
      end
   end

   // Latch pending vector; reset takes no vector
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         pending_vector_number <= 7'h00; // RULE_02
         pending_new_level <= 4'h0;
         o_irq <= 1'b0;
      end
      else
      begin
         o_irq <= next_valid & ~i_ack;
         if (next_valid)
         begin
            pending_vector_number <= next_vector; // RULE_16
            pending_new_level <= next_level;      // RULE_16
         end
      end
   end

   // Entry address of winner
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_vector_addr <= PRIMARY_TABLE_BASE;
      end
      else
      begin
         o_vector_addr <= PRIMARY_TABLE_BASE + {16'h0000, next_vector, 1'b0}
            + (global_irq_control_second[ALT_SELECT_BIT] ? ALT_TABLE_OFFSET : 24'h000000); // RULE_05 RULE_21
      end
   end

   assign o_vector = pending_vector_number;
   assign o_new_level = pending_new_level;
   assign o_nesting_disable = global_irq_control_first[NESTING_DISABLE_BIT];
   assign o_reset_pc = RESET_PC; // RULE_01

   // ****
   // AXI read channel
   // ****
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_ok = (i_araddr[31:8] == 24'h000000) && (i_araddr[1:0] == 2'h0)
         && (i_araddr[7:0] <= OFF_PENDING); // RULE_10
      if (i_araddr[7:0] == OFF_CTRL_FIRST)
         rd_word[15:0] = global_irq_control_first;
      else if (i_araddr[7:0] == OFF_CTRL_SECOND)
         rd_word[15:0] = global_irq_control_second;
      else if (i_araddr[7:0] == OFF_PENDING)
         rd_word[15:0] = {4'h0, pending_new_level, 1'b0, pending_vector_number};
      for (int i = 0; i < NUM_FLAG_REGS; i++)
      begin
         for (int b = 0; b < 16; b++)
         begin
            if (16 * i + b < NUM_SRC && i_araddr[7:0] == OFF_FLAG_BASE + 8'(4 * i))
               rd_word[b] = request_flag_regs[16 * i + b];
            if (16 * i + b < NUM_SRC && i_araddr[7:0] == OFF_ENABLE_BASE + 8'(4 * i))
               rd_word[b] = request_enable_regs[16 * i + b];
         end
      end
      for (int i = 0; i < NUM_PRIO_REGS; i++)
      begin
         for (int f = 0; f < 4; f++)
         begin
            if (4 * i + f < NUM_SRC && i_araddr[7:0] == OFF_PRIO_BASE + 8'(4 * i))
               rd_word[4 * f +: 3] = source_priority_regs[4 * i + f];
         end
      end
   end

   assign o_arready = ~o_rvalid;

   // Read answer one cycle after address
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= RESP_OKAY;
      end
      else if (i_arvalid && o_arready)
      begin
         o_rvalid <= 1'b1;
         o_rdata <= rd_ok ? rd_word : 32'h0000_0000;
         o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (o_rvalid && i_rready)
      begin
         o_rvalid <= 1'b0;
      end
   end
endmodule

// ---- hw/vic_pkg.sv ----
// Functional notes
// RULE_01: Reset clears registers, program starts at zero.
// RULE_02: Reset is not handled as exception.
// RULE_03: Software fills unused vectors with reset handler.
// RULE_04: External request zero is vector 8.
// RULE_05: Vector address is 4 plus 2n, alternate +0x100.
// RULE_06: DMA channels map to fixed vectors.
// RULE_07: Serial port sources map to fixed vectors.
// RULE_08: CAN sources map to vectors 42, 43, 78.
// RULE_09: External, change and comparator vector mapping.
// RULE_10: Thirty registers: control, flag, enable, priority, pending.
// RULE_11: First control holds nesting disable, trap flags.
// RULE_12: Second control holds edge polarity, table select.
// RULE_13: Hardware sets flag, only software write clears.
// RULE_14: Each source has an individual enable bit.
// RULE_15: Each source has a 3-bit priority field; the code has writable fields for sources 0 to 43 only.
// RULE_16: Pending register latches vector and new level.
// RULE_17: New level equals the pending source priority.
// RULE_18: Bit positions follow vector order from zero.
// RULE_19: Eight trap vectors then 118 source vectors.
// RULE_20: Equal priority favours lower vector number.
// RULE_21: Table select chooses alternate table for fetches.
// RULE_22: Request only when flagged, enabled, above CPU level.
// RULE_23: Reserved vectors never pending, read as zero.
package vic_pkg;
   // ****
   // Table geometry
   // ****
   localparam int NUM_TRAPS = 8;
   localparam int NUM_SRC = 118;
   localparam int NUM_FLAG_REGS = 8;
   localparam int NUM_PRIO_REGS = 30 - 2 - 2 * NUM_FLAG_REGS - 1;
   localparam logic [23:0] RESET_PC = 24'h000000;
   localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
   localparam logic [23:0] ALT_TABLE_OFFSET = 24'h000100;
   // Implemented sources, bit = vector - 8
   localparam logic [127:0] SRC_IMPL = 128'h0000_0000_0000_007E_6000_601F_FFDF_7FFF;
   // ****
   // Register byte offsets
   // ****
   localparam logic [7:0] OFF_CTRL_FIRST = 8'h00;
   localparam logic [7:0] OFF_CTRL_SECOND = 8'h04;
   localparam logic [7:0] OFF_FLAG_BASE = 8'h08;
   localparam logic [7:0] OFF_ENABLE_BASE = 8'h28;
   localparam logic [7:0] OFF_PRIO_BASE = 8'h48;
   localparam logic [7:0] OFF_PENDING = 8'h74;
   // ****
   // Field positions
   // ****
   localparam int NESTING_DISABLE_BIT = 15;
   localparam logic [15:0] CTRL_FIRST_MASK = 16'h807E;
   localparam int ALT_SELECT_BIT = 15;
   localparam logic [15:0] CTRL_SECOND_MASK = 16'h8007;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- hw/vic_edge_detect.sv ----
module vic_edge_detect
   import vic_pkg::*;
(
   input wire logic i_ref_clk,   // System clock
   input wire logic i_reset,     // Async reset
   input wire logic i_level,     // External request pin
   input wire logic i_negative,  // Select falling edge
   output logic o_edge           // One-cycle edge pulse
);
   logic last_level; // Previous pin sample

   // ****
   // Pin history
   // ****
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         last_level <= 1'b0;
      end
      else
      begin
         last_level <= i_level;
      end
   end

   // Polarity chosen by control bit
   always_comb
   begin
      o_edge = i_negative ? (last_level & ~i_level) : (~last_level & i_level);
   end
endmodule

// ---- sim/vic_checker.sv ----
module vic_checker
   import vic_pkg::*;
(
   input wire logic i_ref_clk,            // Clock
   input wire logic i_reset,              // Reset
   input wire logic [3:0] i_cpu_level,    // CPU level
   input wire logic i_ack,                // CPU ack
   input wire logic i_arvalid,            // Read address valid
   input wire logic i_bready,             // Write response ready
   input wire logic i_rready,             // Read ready
   input wire logic o_irq,                // Request to CPU
   input wire logic [6:0] o_vector,       // Latched vector
   input wire logic [3:0] o_new_level,    // Latched level
   input wire logic [23:0] o_vector_addr, // Entry address
   input wire logic [23:0] o_reset_pc,    // Start address
   input wire logic o_awready,            // Write address ready
   input wire logic o_wready,             // Write data ready
   input wire logic o_bvalid,             // Write response valid
   input wire logic o_arready,            // Read address ready
   input wire logic o_rvalid,             // Read valid
   input wire logic [31:0] o_rdata        // Read data
);
   // ****
   // Properties on the design's outputs
   // ****
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   reset_pc_zero_a: assert property (o_reset_pc == RESET_PC)
      else $error("start address not zero");
   addr_from_vector_a: assert property (o_irq |-> o_vector_addr[7:0] == 8'h04 + {o_vector, 1'b0}
      && o_vector_addr[23:9] == 15'h0) else $error("entry address wrong");
   no_reserved_vector_a: assert property (o_irq |-> o_vector >= 7'h08
      && SRC_IMPL[o_vector - 7'h08]) else $error("reserved vector pending");
   level_above_cpu_a: assert property (o_irq |-> o_new_level > $past(i_cpu_level)
      && !o_new_level[3]) else $error("request not above CPU level");
   ack_masks_irq_a: assert property (i_ack |=> !o_irq)
      else $error("request stayed after ack");
   bresp_holds_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
      else $error("write response dropped");
   rdata_holds_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data not held");
   read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read not answered");
   read_blocked_a: assert property (o_rvalid |-> !o_arready)
      else $error("read taken while busy");
   write_blocked_a: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken while busy");
endmodule
bind vectored_interrupt_controller vic_checker chk_u (.i_ref_clk, .i_reset, .i_cpu_level, .i_ack,
   .i_arvalid, .i_bready, .i_rready, .o_irq, .o_vector, .o_new_level, .o_vector_addr,
   .o_reset_pc, .o_awready, .o_wready, .o_bvalid, .o_arready, .o_rvalid, .o_rdata);

// ---- sim/vic_cpu_model.sv ----
module vic_cpu_model
   import vic_pkg::*;
(
   input wire logic i_ref_clk,            // Clock
   input wire logic i_reset,              // Reset
   input wire logic i_irq,                // Request from controller
   input wire logic [23:0] i_vector_addr, // Entry address
   input wire logic [3:0] i_level,        // Level to run at
   input wire logic i_take,               // Accept requests
   output logic [3:0] o_cpu_level,        // Current level
   output logic o_ack,                    // Request taken
   output logic [23:0] o_fetch_addr       // Last entry fetched
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Take a request and fetch its entry
   // ****
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_ack <= 1'b0;
         o_fetch_addr <= RESET_PC;
      end
      else
      begin
         o_ack <= i_take && i_irq && !o_ack;
         if (i_take && i_irq && !o_ack)
            o_fetch_addr <= i_vector_addr;
      end
   end
   // Level set by bench
   assign o_cpu_level = i_level;
endmodule

// ---- sim/vectored_interrupt_controller_tb.sv ----
module vectored_interrupt_controller_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import vic_pkg::*;
   // ****
   // Signals
   // ****
   logic i_ref_clk = 1'b0, i_reset = 1'b1; // Clock, reset
   logic [NUM_SRC-1:0] i_src_request = '0; // Source lines
   logic i_ext_zero = 1'b0, i_ext_one = 1'b0, i_ext_two = 1'b0; // Pins
   logic [5:0] i_trap_event = '0; // Trap pulses
   logic [31:0] i_awaddr = '0, i_wdata = '0, i_araddr = '0; // Bus payload
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
   logic [3:0] i_wstrb = 4'hF, lvl = 4'h0, i_cpu_level, o_new_level; // Strobes, levels
   logic take = 1'b0, alt = 1'b0; // Model ack, table select
   logic i_ack, o_irq, o_nesting_disable, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [6:0] o_vector;
   logic [23:0] o_vector_addr, o_reset_pc, fetch;
   logic [1:0] o_bresp, o_rresp, rr;
   logic [31:0] o_rdata, rd, rng = 32'h52;
   int failures = 0, checks_done = 0;
   int vt [23] = '{8, 12, 19, 20, 22, 26, 27, 28, 32, 37, 38, 39, 42, 43, 44, 54, 69, 73, 74, 75,
      76, 77, 78};
   always #10 i_ref_clk = ~i_ref_clk;
   vectored_interrupt_controller dut_u (.i_ref_clk, .i_reset, .i_src_request, .i_ext_zero,
      .i_ext_one, .i_ext_two, .i_cpu_level, .i_trap_event, .i_ack, .o_irq, .o_vector,
      .o_new_level, .o_vector_addr, .o_nesting_disable, .o_reset_pc, .i_awaddr, .i_awvalid,
      .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
      .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
   vic_cpu_model cpu_u (.i_ref_clk, .i_reset, .i_irq(o_irq), .i_vector_addr(o_vector_addr),
      .i_level(lvl), .i_take(take), .o_cpu_level(i_cpu_level), .o_ack(i_ack),
      .o_fetch_addr(fetch));
   // ****
   // Helpers
   // ****
   task automatic give_verdict();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic stuck();
      failures++;
      give_verdict();
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want)
      begin
         failures++;
         $display("unexpected at %0t: seen %h want %h", $time, seen, want);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [23:0] exp_addr(input int v);
      return PRIMARY_TABLE_BASE + 24'(2 * v) + (alt ? ALT_TABLE_OFFSET : 24'h0);
   endfunction
   // Random source with a priority field, no pin
   function automatic int pick();
      int s;
      s = 0;
      for (int t = 0; t < 200 && (s == 0 || s == 20 || s == 29 || !SRC_IMPL[s]); t++)
      begin
         rng = xs(rng);
         s = int'(rng % 44);
      end
      return s;
   endfunction
   // Write: both offered, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge i_ref_clk);
      i_awaddr <= {24'h0, a};
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      for (n = 0; n < 40 && (n == 0 || i_awvalid || i_wvalid || i_bready); n++)
      begin
         @(posedge i_ref_clk);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
         if (i_bready && o_bvalid) i_bready <= 1'b0;
      end
      if (n >= 40) stuck();
   endtask
   // Read: data taken at the rvalid edge
   task automatic axi_rd(input logic [7:0] a);
      int n;
      @(posedge i_ref_clk);
      i_araddr <= {24'h0, a};
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      for (n = 0; n < 40 && (n == 0 || i_arvalid || i_rready); n++)
      begin
         @(posedge i_ref_clk);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
         if (i_rready && o_rvalid)
         begin
            rd = o_rdata;
            rr = o_rresp;
            i_rready <= 1'b0;
         end
      end
      if (n >= 40) stuck();
   endtask
   task automatic wait_irq();
      int n;
      for (n = 0; n < 12 && o_irq !== 1'b1; n++)
         @(posedge i_ref_clk);
      check(o_irq, 1'b1);
      if (n >= 12) stuck();
   endtask
   task automatic quiet();
      repeat (4) @(posedge i_ref_clk);
      check(o_irq, 1'b0);
   endtask
   // One request cycle
   task automatic pulse(input int v);
      @(posedge i_ref_clk);
      if (v == 8) i_ext_zero <= 1'b1;
      else if (v == 28) i_ext_one <= 1'b1;
      else if (v == 37) i_ext_two <= 1'b1;
      else i_src_request[v - 8] <= 1'b1;
      @(posedge i_ref_clk);
      i_src_request <= '0;
      {i_ext_zero, i_ext_one, i_ext_two} <= 3'h0;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic serve(input int v, input int p);
      int s;
      logic [7:0] fo;
      s = v - 8;
      fo = 8'(s / 16 * 4);
      pulse(v);
      axi_rd(OFF_FLAG_BASE + fo);
      check(rd, 32'h1 << (s % 16));
      if (s < 44)
      begin
         axi_wr(OFF_PRIO_BASE + 8'(s / 4 * 4), 32'(p) << (s % 4 * 4));
         axi_wr(OFF_ENABLE_BASE + fo, 32'h1 << (s % 16));
         wait_irq();
         check(o_vector, v);
         check(o_new_level, p);
         check(o_vector_addr, exp_addr(v));
         axi_rd(OFF_PENDING);
         check(rd, (p << 8) | v);
         axi_wr(OFF_ENABLE_BASE + fo, 32'h0);
         quiet();
      end
      axi_wr(OFF_FLAG_BASE + fo, 32'h0);
      axi_rd(OFF_FLAG_BASE + fo);
      check(rd, 32'h0);
   endtask
   task automatic pair_run(input int k);
      int s1, s2, p1, p2, w, pw, i;
      logic [31:0] en [8] = '{default: 32'h0};
      logic [31:0] pr [11] = '{default: 32'h0};
      s1 = pick();
      s2 = pick();
      for (i = 0; i < 20 && s2 == s1; i++) s2 = pick();
      p1 = 1 + int'(rng % 7);
      p2 = (k % 2 == 0) ? p1 : 1 + int'((rng >> 8) % 7);
      en[s1 / 16][s1 % 16] = 1'b1;
      en[s2 / 16][s2 % 16] = 1'b1;
      pr[s1 / 4] |= 32'(p1) << (s1 % 4 * 4);
      pr[s2 / 4] |= 32'(p2) << (s2 % 4 * 4);
      for (i = 0; i < 11; i++) axi_wr(OFF_PRIO_BASE + 8'(4 * i), pr[i]);
      for (i = 0; i < 8; i++) axi_wr(OFF_ENABLE_BASE + 8'(4 * i), en[i]);
      @(posedge i_ref_clk);
      i_src_request <= (NUM_SRC'(1) << s1) | (NUM_SRC'(1) << s2);
      @(posedge i_ref_clk);
      i_src_request <= '0;
      w = (p1 > p2 || (p1 == p2 && s1 < s2)) ? s1 : s2;
      pw = (w == s1) ? p1 : p2;
      wait_irq();
      check(o_vector, w + 8);
      check(o_new_level, pw);
      lvl <= 4'(pw);
      quiet();
      lvl <= 4'h0;
      take <= 1'b1;
      repeat (6) @(posedge i_ref_clk);
      check(fetch, exp_addr(w + 8));
      take <= 1'b0;
      for (i = 0; i < 8; i++) axi_wr(OFF_FLAG_BASE + 8'(4 * i), 32'h0);
   endtask
   initial
   begin
      repeat (8) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      @(posedge i_ref_clk);
      check(o_irq, 1'b0);
      check(o_vector_addr, PRIMARY_TABLE_BASE);
      check(o_reset_pc, 24'h0);
      for (int a = 0; a < 30; a++)
      begin
         axi_rd(8'(4 * a));
         check(rd, 32'h0);
         check(rr, RESP_OKAY);
      end
      axi_rd(8'h78);
      check(rr, RESP_SLVERR);
      pulse(23);
      axi_rd(OFF_FLAG_BASE);
      check(rd, 32'h0);
      axi_wr(OFF_CTRL_FIRST, 32'h8000);
      @(posedge i_ref_clk) i_trap_event <= 6'h3F;
      @(posedge i_ref_clk) i_trap_event <= 6'h0;
      check(o_nesting_disable, 1'b1);
      axi_rd(OFF_CTRL_FIRST);
      check(rd, 32'h807E);
      for (int i = 0; i < 23; i++)
      begin
         if (i == 12)
         begin
            axi_wr(OFF_CTRL_SECOND, 32'h8000);
            alt = 1'b1;
            axi_rd(OFF_CTRL_SECOND);
            check(rd, 32'h8000);
         end
         serve(vt[i], 1 + i % 7);
      end
      for (int k = 0; k < 8; k++) pair_run(k);
      give_verdict();
   end
endmodule
